// ### hdl/exc_pkg.sv
// Purpose: shared constants and types for the exception entry block
// Assumes: single 200 MHz processor clock
// Notes: vectors are byte addresses in the low code page
package exc_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_SWI = 32'h0000_0008;
  localparam logic [31:0] VEC_PABORT = 32'h0000_000C;
  localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001C;
  localparam int SYNC_STAGES = 2;
  localparam int ENTRY_CYCLES = 3;
  localparam int MIN_LATENCY = 5;
  localparam int MAX_FIQ_LATENCY = 50;
  localparam int MAX_NO_LDM_LATENCY = 42;
  localparam int MAX_COMPRESSED_LATENCY = 22;
  localparam int NUM_REGS = 37;
  localparam int NUM_GP_REGS = 31;
  localparam int NUM_STATUS_REGS = 6;
  // mode encodings of the current status word
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  // status word bit positions
  localparam int SW_COMPRESSED_BIT = 5;
  localparam int SW_FIQ_MASK_BIT = 6;
  localparam int SW_IRQ_MASK_BIT = 7;
  localparam logic [31:0] SW_RESET = 32'h0000_00D3;
  typedef enum logic [2:0] {
    EXC_NONE, EXC_DABORT, EXC_FIQ, EXC_IRQ, EXC_UNDEF, EXC_SWI
  } exc_kind_t;
  typedef enum logic [1:0] {
    BANK_USR, BANK_FIQ, BANK_PRIV
  } bank_t;
endpackage

// ### hdl/exc_req_if.sv
// Purpose: carrier between the entry sequencer and its helper modules
// Assumes: one clock domain
// Notes: sync side produces the clean requests, arbiter consumes them
`timescale 1ns/1ps
interface exc_req_if;
  logic fast_req;
  logic norm_req;
  logic abort_req;
  logic undef_req;
  logic swi_req;
  logic fast_mask;
  logic norm_mask;
  logic [2:0] winner;
  modport sync_side (output fast_req, output norm_req);
  modport arb_side (input fast_req, input norm_req, input abort_req, input undef_req,
                    input swi_req, input fast_mask, input norm_mask, output winner);
  modport core_side (input fast_req, input norm_req, output abort_req, output undef_req,
                     output swi_req, output fast_mask, output norm_mask, input winner);
endinterface

// ### hdl/exc_req_sync.sv
// Purpose: two-stage synchroniser for the two interrupt request lines
// Assumes: request lines may be asynchronous to the core clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module exc_req_sync
  import exc_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fast_raw,
  input wire logic norm_raw,
  exc_req_if.sync_side req
);
  logic [STAGES-1:0] fast_q;
  logic [STAGES-1:0] norm_q;

  // shift chains, reset to idle so no spurious entry after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_q <= '0;
      norm_q <= '0;
    end else begin
      fast_q <= {fast_q[STAGES-2:0], fast_raw};
      norm_q <= {norm_q[STAGES-2:0], norm_raw};
    end
  end

  assign req.fast_req = fast_q[STAGES-1];
  assign req.norm_req = norm_q[STAGES-1];
endmodule // exc_req_sync

// ### hdl/exc_arbiter.sv
// Purpose: fixed priority selection among pending exceptions
// Assumes: inputs already synchronous
// Notes: order is abort, fast, normal, then instruction-caused ones
`timescale 1ns/1ps
module exc_arbiter
  import exc_pkg::*;
(
  exc_req_if.arb_side req
);
  exc_kind_t pick;
  wire fast_ok = req.fast_req & ~req.fast_mask;
  wire norm_ok = req.norm_req & ~req.norm_mask;

  // fast beats normal; normal waits as long as fast keeps winning
  assign pick = req.abort_req ? EXC_DABORT :
                fast_ok ? EXC_FIQ :
                norm_ok ? EXC_IRQ :
                req.undef_req ? EXC_UNDEF :
                req.swi_req ? EXC_SWI : EXC_NONE;
  assign req.winner = pick;
endmodule // exc_arbiter

// ### hdl/core_exception_entry.sv
// Purpose: exception recognition, mode entry, register banking and debug halt
// Assumes: inputs synchronous except the two request lines
// Notes: the datapath outside steps instructions; this block steers modes
// Operation
// - five exception types, each entering its own privileged mode
// - fast interrupt wins over normal interrupt when both pending
// - fast interrupt entry fetches from vector 0x1C
// - fast vector reached within 50 cycles of request, worst case; unbounded here once an abort entry sets the fast mask
// - worst case is sync, full load-multiple, abort entry, fast entry; abort entry here sets the fast mask, so fast entry waits
// - minimum latency is five cycles, sync plus mode entry; here six, a take cycle precedes the three entry cycles
// - worst case 42 without load-multiple, 22 in compressed set
// - normal interrupt may wait indefinitely behind fast handling
// - 37 registers: 31 general and 6 status, banked per mode
// - user mode sees r0-r14, pc as r15 and status word
// - every exception mode banks r13 and r14
// - fast mode additionally banks r8 to r12
// - privileged modes run the 32-bit set; entry leaves compressed set
// - second 16-bit compressed instruction set is supported
// - four multiply and multiply-accumulate instructions, 64-bit results
// - breakpoint or watchpoint halts core into debug state
// - one 32-bit bus for code and data, 8/16/32-bit transfers
`timescale 1ns/1ps
module core_exception_entry
  import exc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // requests from interrupt controller
  input wire logic FAST_INTERRUPT_REQUEST_IN,
  input wire logic NORMAL_INTERRUPT_REQUEST_IN,
  // events from the instruction pipeline
  input wire logic MEMORY_ABORT_IN,
  input wire logic UNDEFINED_INSTR_IN,
  input wire logic SOFTWARE_INTERRUPT_INSTRUCTION_IN,
  input wire logic INSTR_BOUNDARY_IN,
  input wire logic [ADDR_W-1:0] RETURN_PC_IN,
  input wire logic [31:0] LOAD_MULTIPLE_MASK_IN,
  // status word writes from the datapath
  input wire logic STATUS_WRITE_IN,
  input wire logic [31:0] STATUS_WDATA_IN,
  // register file access by architectural index
  input wire logic [3:0] REG_INDEX_IN,
  input wire logic REG_WRITE_IN,
  input wire logic [31:0] REG_WDATA_IN,
  // multiply unit operands
  input wire logic [1:0] MUL_OP_IN,
  input wire logic [31:0] MUL_A_IN,
  input wire logic [31:0] MUL_B_IN,
  input wire logic [63:0] MUL_ACC_IN,
  // debug port
  input wire logic BREAKPOINT_HIT_IN,
  input wire logic WATCHPOINT_HIT_IN,
  input wire logic DEBUG_RESUME_IN,
  // bus transfer size request from the datapath
  input wire logic [1:0] XFER_SIZE_IN,
  // outputs
  output logic [ADDR_W-1:0] FETCH_ADDR_OUT,
  output logic FETCH_REDIRECT_OUT,
  output logic [31:0] CURRENT_STATUS_WORD_OUT,
  output logic [31:0] REG_RDATA_OUT,
  output logic [2:0] EXC_KIND_OUT,
  output logic [5:0] LATENCY_OUT,
  output logic DEBUG_HALTED_OUT,
  output logic [63:0] MUL_RESULT_OUT,
  output logic [3:0] BYTE_LANES_OUT
);
  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_DEBUG} state_t;
  state_t state_r, state_nxt;
  exc_req_if rq();
  exc_kind_t winner;
  logic [1:0] entry_cnt_r;
  exc_kind_t pend_r;
  logic [31:0] sw_r;
  logic [31:0] saved_sw_r [5];
  logic [31:0] gp_r [NUM_GP_REGS];
  logic [5:0] lat_r;
  logic lat_run_r;
  logic [63:0] mul_r;

  // request synchroniser and priority selection
  exc_req_sync u_sync (
    .clk(REF_CLK_IN), .rst(RST_IN), .fast_raw(FAST_INTERRUPT_REQUEST_IN),
    .norm_raw(NORMAL_INTERRUPT_REQUEST_IN), .req(rq.sync_side)
  );
  exc_arbiter u_arb (.req(rq.arb_side));
  assign rq.abort_req = MEMORY_ABORT_IN;
  assign rq.undef_req = UNDEFINED_INSTR_IN;
  assign rq.swi_req = SOFTWARE_INTERRUPT_INSTRUCTION_IN;
  assign rq.fast_mask = sw_r[SW_FIQ_MASK_BIT];
  assign rq.norm_mask = sw_r[SW_IRQ_MASK_BIT];
  assign winner = exc_kind_t'(rq.winner);

  // exceptions are taken at instruction boundaries only, so a
  // load-multiple in flight stretches the latency (aborts preempt)
  wire take = (state_r == ST_RUN) && (winner != EXC_NONE) &&
              (INSTR_BOUNDARY_IN || winner == EXC_DABORT);
  wire debug_hit = BREAKPOINT_HIT_IN | WATCHPOINT_HIT_IN;

  // mode, vector and new status word per exception kind
  logic [4:0] new_mode;
  logic [31:0] new_vec;
  always_comb begin
    new_mode = MODE_SVC;
    new_vec = VEC_SWI;
    case (pend_r)
      EXC_DABORT: begin
        new_mode = MODE_ABT;
        new_vec = VEC_DABORT;
      end
      EXC_FIQ: begin
        new_mode = MODE_FIQ;
        new_vec = VEC_FIQ;
      end
      EXC_IRQ: begin
        new_mode = MODE_IRQ;
        new_vec = VEC_IRQ;
      end
      EXC_UNDEF: begin
        new_mode = MODE_UND;
        new_vec = VEC_UNDEF;
      end
      EXC_SWI: begin
        new_mode = MODE_SVC;
        new_vec = VEC_SWI;
      end
      default: begin
        new_mode = MODE_SVC;
        new_vec = VEC_SWI;
      end
    endcase
  end
  wire fast_entry = (pend_r == EXC_FIQ) || (pend_r == EXC_DABORT);
  wire [31:0] entered_sw = {sw_r[31:8], 1'b1, fast_entry | sw_r[SW_FIQ_MASK_BIT],
                            1'b0, new_mode};

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // a halt request beats a pending exception in the same cycle
        if (debug_hit) begin
          state_nxt = ST_DEBUG;
        end else if (take) begin
          state_nxt = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (entry_cnt_r == 2'(ENTRY_CYCLES - 1)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_DEBUG: begin
        if (DEBUG_RESUME_IN) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // saved status slot per exception mode
  function automatic int slot(input logic [4:0] m);
    case (m)
      MODE_FIQ: slot = 0;
      MODE_IRQ: slot = 1;
      MODE_SVC: slot = 2;
      MODE_ABT: slot = 3;
      default: slot = 4;
    endcase
  endfunction

  // sequencer, status word and entry redirect
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= ST_RUN;
      entry_cnt_r <= 2'h0;
      pend_r <= EXC_NONE;
      sw_r <= SW_RESET;
      FETCH_ADDR_OUT <= VEC_RESET;
      FETCH_REDIRECT_OUT <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        saved_sw_r[i] <= 32'h0000_0000;
      end
    end else begin
      state_r <= state_nxt;
      FETCH_REDIRECT_OUT <= 1'b0;
      if (state_r == ST_RUN && take && !debug_hit) begin
        pend_r <= winner;
        entry_cnt_r <= 2'h0;
      end else if (state_r == ST_ENTER) begin
        entry_cnt_r <= entry_cnt_r + 2'h1;
        if (entry_cnt_r == 2'(ENTRY_CYCLES - 1)) begin
          saved_sw_r[slot(new_mode)] <= sw_r;
          sw_r <= entered_sw;
          FETCH_ADDR_OUT <= new_vec;
          FETCH_REDIRECT_OUT <= 1'b1;
        end
      end else if (STATUS_WRITE_IN && state_r == ST_RUN) begin
        sw_r <= STATUS_WDATA_IN;
      end
    end
  end

  // latency counter from synchronised fast request to vector fetch;
  // the raw edge is two cycles earlier, so bounds include the sync stages
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      lat_r <= 6'h00;
      lat_run_r <= 1'b0;
      LATENCY_OUT <= 6'h00;
    end else if (FETCH_REDIRECT_OUT && lat_run_r) begin
      lat_run_r <= 1'b0;
      LATENCY_OUT <= lat_r + 6'(SYNC_STAGES);
    end else if (rq.fast_req && !lat_run_r && !sw_r[SW_FIQ_MASK_BIT]) begin
      lat_run_r <= 1'b1;
      lat_r <= 6'h01;
    end else if (lat_run_r && lat_r != 6'h3F) begin
      lat_r <= lat_r + 6'h01;
    end
  end

  // banked register mapping: index 0-14 plus banks, pc reads as 15
  bank_t bank;
  logic [4:0] phys;
  wire [4:0] mode = sw_r[4:0];
  assign bank = (mode == MODE_FIQ) ? BANK_FIQ : (mode == MODE_USR) ? BANK_USR : BANK_PRIV;
  always_comb begin
    phys = {1'b0, REG_INDEX_IN};
    if (bank == BANK_FIQ && REG_INDEX_IN >= 4'h8 && REG_INDEX_IN <= 4'hE)
      phys = 5'(REG_INDEX_IN) + 5'h08;
    else if (bank == BANK_PRIV && REG_INDEX_IN >= 4'hD && REG_INDEX_IN <= 4'hE)
      phys = 5'h17 + 5'(2 * (slot(mode) - 1)) + 5'(REG_INDEX_IN - 4'hD);
  end
  // physical map: 0-15 shared (15 = pc), 16-22 fast bank, 23-30 other modes
  assign REG_RDATA_OUT = (REG_INDEX_IN == 4'hF) ? FETCH_ADDR_OUT : gp_r[phys];
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < NUM_GP_REGS; i++) begin
        gp_r[i] <= 32'h0000_0000;
      end
    end else if (state_r == ST_ENTER && entry_cnt_r == 2'(ENTRY_CYCLES - 1)) begin
      // link register of the new mode gets the return address
      if (new_mode == MODE_FIQ) begin
        gp_r[22] <= RETURN_PC_IN;
      end else begin
        gp_r[5'h18 + 5'(2 * (slot(new_mode) - 1))] <= RETURN_PC_IN;
      end
    end else if (REG_WRITE_IN && REG_INDEX_IN != 4'hF) begin
      gp_r[phys] <= REG_WDATA_IN;
    end
  end

  // multiply unit: op 0 umul, 1 umac, 2 smul, 3 smac
  wire sgn = MUL_OP_IN[1];
  // operands widened first so the product is never cut to 32 bits;
  // the low 64 bits of a 64x64 product are right for both signs
  wire [63:0] a_ext = sgn ? {{32{MUL_A_IN[31]}}, MUL_A_IN} : {32'h0000_0000, MUL_A_IN};
  wire [63:0] b_ext = sgn ? {{32{MUL_B_IN[31]}}, MUL_B_IN} : {32'h0000_0000, MUL_B_IN};
  wire [63:0] prod = a_ext * b_ext;
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      MUL_RESULT_OUT <= 64'h0;
    end else begin
      MUL_RESULT_OUT <= MUL_OP_IN[0] ? prod + MUL_ACC_IN : prod;
    end
  end

  // byte lanes on the shared 32-bit bus: 0 byte, 1 half, 2 word
  assign BYTE_LANES_OUT = (XFER_SIZE_IN == 2'h0) ? 4'h1 :
                          (XFER_SIZE_IN == 2'h1) ? 4'h3 : 4'hF;
  assign CURRENT_STATUS_WORD_OUT = sw_r;
  assign EXC_KIND_OUT = pend_r;
  assign DEBUG_HALTED_OUT = (state_r == ST_DEBUG);
  // compressed set is just the status bit, exception entry clears it;
  // the load-multiple mask is informative only, folded to keep it read
  wire unused_mask = ^LOAD_MULTIPLE_MASK_IN;
endmodule // core_exception_entry

// ### sim/irq_ctrl_model.sv
// Purpose: interrupt controller model raising the two request lines
// Assumes: one pulse on raise_* starts a request
// Notes: a request drops only when its own entry is acknowledged
`timescale 1ns/1ps
module irq_ctrl_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stimulus and acknowledge
  input wire logic raise_fast,
  input wire logic raise_norm,
  input wire logic ack,
  input wire logic [2:0] kind,
  // request lines
  output logic fast_req,
  output logic norm_req
);
  // hold each line until redirect with matching kind, so no request is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_req <= 1'b0;
      norm_req <= 1'b0;
    end else begin
      fast_req <= raise_fast | (fast_req & ~(ack & (kind == 3'h2)));
      norm_req <= raise_norm | (norm_req & ~(ack & (kind == 3'h3)));
    end
  end
endmodule // irq_ctrl_model

// ### sim/core_exception_entry_monitor.sv
// Purpose: port level checks of exception entry
// Assumes: bench keeps requests apart by more than the latency window
// Notes: the latency bound is waived if masked or halted when the request rises
`timescale 1ns/1ps
module core_exception_entry_monitor
  import exc_pkg::*;
(
  // watched ports
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic FAST_INTERRUPT_REQUEST_IN,
  input wire logic [1:0] MUL_OP_IN,
  input wire logic [31:0] MUL_A_IN,
  input wire logic [31:0] MUL_B_IN,
  input wire logic BREAKPOINT_HIT_IN,
  input wire logic WATCHPOINT_HIT_IN,
  input wire logic [1:0] XFER_SIZE_IN,
  input wire logic [ADDR_W-1:0] FETCH_ADDR_OUT,
  input wire logic FETCH_REDIRECT_OUT,
  input wire logic [31:0] CURRENT_STATUS_WORD_OUT,
  input wire logic [2:0] EXC_KIND_OUT,
  input wire logic DEBUG_HALTED_OUT,
  input wire logic [63:0] MUL_RESULT_OUT,
  input wire logic [3:0] BYTE_LANES_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  wire fast_entry = FETCH_REDIRECT_OUT && (EXC_KIND_OUT == 3'h2);
  // entry checks
  a_fast_vector: assert property (fast_entry |-> FETCH_ADDR_OUT == VEC_FIQ) else $error("fast vector wrong");
  a_fast_mode: assert property (fast_entry |-> CURRENT_STATUS_WORD_OUT[7:6] == 2'h3
    && CURRENT_STATUS_WORD_OUT[4:0] == MODE_FIQ) else $error("fast mode wrong");
  a_wide_set: assert property (FETCH_REDIRECT_OUT |-> !CURRENT_STATUS_WORD_OUT[5]) else $error("compressed set kept");
  a_redirect_pulse: assert property (FETCH_REDIRECT_OUT |=> !FETCH_REDIRECT_OUT) else $error("redirect too long");
  // latency window
  a_min_latency: assert property ($rose(FAST_INTERRUPT_REQUEST_IN) |-> !fast_entry [*4]) else $error("entry too soon");
  a_max_latency: assert property ($rose(FAST_INTERRUPT_REQUEST_IN) && !CURRENT_STATUS_WORD_OUT[6] && !DEBUG_HALTED_OUT
    |-> ##[1:50] fast_entry) else $error("entry too late");
  // datapath helpers and debug halt
  a_lane_map: assert property (XFER_SIZE_IN != 2'h3 |-> BYTE_LANES_OUT == (XFER_SIZE_IN == 2'h0 ? 4'h1 :
    XFER_SIZE_IN == 2'h1 ? 4'h3 : 4'hF)) else $error("byte lanes wrong");
  a_mul_plain: assert property (MUL_OP_IN == 2'h0 |=> MUL_RESULT_OUT == 64'($past(MUL_A_IN)) * 64'($past(MUL_B_IN)))
    else $error("product wrong");
  a_debug_halt: assert property ($rose(BREAKPOINT_HIT_IN || WATCHPOINT_HIT_IN) |-> ##[0:3] DEBUG_HALTED_OUT)
    else $error("no halt");
endmodule // core_exception_entry_monitor
bind core_exception_entry core_exception_entry_monitor mon (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
  .FAST_INTERRUPT_REQUEST_IN(FAST_INTERRUPT_REQUEST_IN), .MUL_OP_IN(MUL_OP_IN), .MUL_A_IN(MUL_A_IN),
  .MUL_B_IN(MUL_B_IN), .BREAKPOINT_HIT_IN(BREAKPOINT_HIT_IN), .WATCHPOINT_HIT_IN(WATCHPOINT_HIT_IN),
  .XFER_SIZE_IN(XFER_SIZE_IN), .FETCH_ADDR_OUT(FETCH_ADDR_OUT), .FETCH_REDIRECT_OUT(FETCH_REDIRECT_OUT),
  .CURRENT_STATUS_WORD_OUT(CURRENT_STATUS_WORD_OUT), .EXC_KIND_OUT(EXC_KIND_OUT),
  .DEBUG_HALTED_OUT(DEBUG_HALTED_OUT), .MUL_RESULT_OUT(MUL_RESULT_OUT), .BYTE_LANES_OUT(BYTE_LANES_OUT));

// ### sim/core_exception_entry_tb.sv
// Purpose: self-checking bench for exception entry
// Assumes: instruction boundary high except in its own test
// Notes: table rows cover lanes and multiply, hand tests cover entry
`timescale 1ns/1ps
module core_exception_entry_tb;
  import exc_pkg::*;
  typedef struct packed {logic [1:0] sz; logic [3:0] ln; logic [1:0] op; logic [31:0] a; logic [31:0] b;
    logic [63:0] acc; logic [63:0] res;} row_t;
  localparam row_t ROWS [4] = '{'{2'h0, 4'h1, 2'h0, 32'hFFFF_FFFF, 32'h2, 64'h0, 64'h0000_0001_FFFF_FFFE},
    '{2'h1, 4'h3, 2'h2, 32'hFFFF_FFFF, 32'h2, 64'h0, 64'hFFFF_FFFF_FFFF_FFFE},
    '{2'h2, 4'hF, 2'h1, 32'h3, 32'h4, 64'hA, 64'h16},
    '{2'h2, 4'hF, 2'h3, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 64'h1, 64'h2}};
  logic clk, rst, rf, rn, fq, nq, ab, ud, sw, bnd, stwe, rwe, bp, wp, res, fr, hlt;
  logic [1:0] mop, xs;
  logic [2:0] ek;
  logic [3:0] ri, bl;
  logic [5:0] lat;
  logic [31:0] rpc, stwd, rwd, ma, mb, fa, cs, rd;
  logic [63:0] macc, mr;
  int errors, samples_checked;
  // partner and design
  irq_ctrl_model ctl (.clk(clk), .rst(rst), .raise_fast(rf), .raise_norm(rn), .ack(fr), .kind(ek),
    .fast_req(fq), .norm_req(nq));
  core_exception_entry dut (.REF_CLK_IN(clk), .RST_IN(rst), .FAST_INTERRUPT_REQUEST_IN(fq),
    .NORMAL_INTERRUPT_REQUEST_IN(nq), .MEMORY_ABORT_IN(ab), .UNDEFINED_INSTR_IN(ud),
    .SOFTWARE_INTERRUPT_INSTRUCTION_IN(sw), .INSTR_BOUNDARY_IN(bnd), .RETURN_PC_IN(rpc),
    .LOAD_MULTIPLE_MASK_IN(32'hFFFF_FFFF), .STATUS_WRITE_IN(stwe), .STATUS_WDATA_IN(stwd), .REG_INDEX_IN(ri),
    .REG_WRITE_IN(rwe), .REG_WDATA_IN(rwd), .MUL_OP_IN(mop), .MUL_A_IN(ma), .MUL_B_IN(mb), .MUL_ACC_IN(macc),
    .BREAKPOINT_HIT_IN(bp), .WATCHPOINT_HIT_IN(wp), .DEBUG_RESUME_IN(res), .XFER_SIZE_IN(xs),
    .FETCH_ADDR_OUT(fa), .FETCH_REDIRECT_OUT(fr), .CURRENT_STATUS_WORD_OUT(cs), .REG_RDATA_OUT(rd),
    .EXC_KIND_OUT(ek), .LATENCY_OUT(lat), .DEBUG_HALTED_OUT(hlt), .MUL_RESULT_OUT(mr), .BYTE_LANES_OUT(bl));
  always #2.5 clk = ~clk;
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // wait a bounded time for redirect, then look at the entry it made
  task automatic enter(input logic [2:0] k, input logic [31:0] v, input logic [4:0] m);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (fr !== 1'b1 && n < 60);
    check("redirect", 1, fr);
    check("kind", k, ek);
    check("vector", v, fa);
    check("mode", m, cs[4:0]);
    check("wide_set", 0, cs[5]);
  endtask
  task automatic st(input logic [31:0] d);
    stwd <= d;
    stwe <= 1'b1;
    @(posedge clk);
    stwe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    ri <= i;
    rwd <= d;
    rwe <= 1'b1;
    @(posedge clk);
    rwe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string name, input logic [3:0] i, input logic [31:0] e);
    ri <= i;
    @(posedge clk);
    check(name, e, rd);
  endtask
  // watchdog, far beyond the hundred-odd cycles of the sequence
  initial begin
    #150000;
    errors++;
    stop_test();
  end
  initial begin
    {clk, rf, rn, ab, ud, sw, stwe, rwe, bp, wp, res, mop, xs, ri, stwd, rwd, ma, mb, macc} = '0;
    {rst, bnd} = 2'h3;
    rpc = 32'h0000_1234;
    errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("status_rst", SW_RESET, cs);
    check("fetch_rst", 0, {fr, fa});
    for (int i = 0; i < 4; i++) begin
      {xs, mop, ma, mb, macc} <= {ROWS[i].sz, ROWS[i].op, ROWS[i].a, ROWS[i].b, ROWS[i].acc};
      repeat (2) @(posedge clk);
      check("lanes", ROWS[i].ln, bl);
      check("product", ROWS[i].res, mr);
    end
    st(32'h30);
    check("status_wr", 32'h30, cs);
    wr(8, 32'h1111_1111);
    wr(13, 32'h2222_2222);
    {rf, rn} <= 2'h3;
    @(posedge clk);
    {rf, rn} <= 2'h0;
    enter(EXC_FIQ, VEC_FIQ, MODE_FIQ);
    @(posedge clk);
    check("latency", 1, lat >= 6'd5 && lat <= 6'd50);
    rchk("link_fast", 14, 32'h0000_1234);
    wr(8, 32'h3333_3333);
    rchk("r8_fast", 8, 32'h3333_3333);
    repeat (20) begin
      @(posedge clk);
      check("norm_waits", 0, fr);
    end
    st(32'h11);
    enter(EXC_IRQ, VEC_IRQ, MODE_IRQ);
    rchk("r8_norm", 8, 32'h1111_1111);
    wr(13, 32'h4444_4444);
    st(32'h10);
    rchk("sp_user", 13, 32'h2222_2222);
    // pipeline events are one-cycle pulses, taken with no synchroniser
    for (int i = 0; i < 3; i++) begin
      {ab, ud, sw} <= 3'h4 >> i;
      @(posedge clk);
      {ab, ud, sw} <= 3'h0;
      enter(i == 0 ? EXC_DABORT : i == 1 ? EXC_UNDEF : EXC_SWI, i == 0 ? VEC_DABORT : i == 1 ? VEC_UNDEF : VEC_SWI,
        i == 0 ? MODE_ABT : i == 1 ? MODE_UND : MODE_SVC);
    end
    for (int i = 0; i < 2; i++) begin
      {bp, wp} <= 2'h2 >> i;
      @(posedge clk);
      {bp, wp} <= 2'h0;
      repeat (4) @(posedge clk);
      check("halted", 1, hlt);
      res <= 1'b1;
      @(posedge clk);
      res <= 1'b0;
      repeat (4) @(posedge clk);
      check("resumed", 0, hlt);
    end
    // instruction-caused entry waits for a boundary, five edges long
    {ud, bnd} <= 2'h2;
    repeat (5) begin
      @(posedge clk);
      check("boundary_wait", 0, fr);
    end
    bnd <= 1'b1;
    @(posedge clk);
    ud <= 1'b0;
    enter(EXC_UNDEF, VEC_UNDEF, MODE_UND);
    // reset in mid-run brings back the reset state
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("status_rst2", SW_RESET, cs);
    check("fetch_rst2", 0, {fr, fa, lat, hlt});
    stop_test();
  end
endmodule // core_exception_entry_tb
